/* File: hdl/pmuc_host_control_port.sv */
// host control port of the power unit: serial slave, register file, enables, faults, reset stretch
// Notes on behaviour
// - data line changes only while serial clock is low, steady when high.
// - data falling while clock high starts a session; device detects it.
// - data rising while clock high ends a session; device detects it.
// - bus counts busy from start until the next stop, then idle.
// - repeated start behaves like a first start, restarting address reception.
// - every byte is eight bits, most significant first.
// - no limit on bytes per session.
// - ninth clock carries acknowledge; transmitter releases, receiver pulls low.
// - once addressed as receiver, the device acknowledges every byte.
// - first byte is seven address bits plus direction, 0 write, 1 read.
// - respond only to slave address 46 hex, ignore all others.
// - in a write, second byte selects register, third byte is its value.
// - processor reset asserted on power-on start and on button press.
// - each processor reset assertion lasts at least fifty milliseconds.
// - low reset button input forces reset unconditionally.
// - low-voltage group enable turns on core switcher and linear regs 1, 2, 7.
// - high-voltage group enable turns on memory switcher and remaining linear regs.
// - always-on regulator has no enable and stays active.
// - supply fault low when any enabled supply is low; disabled ones never count.
// - battery fault low when main battery is removed or discharged.
// - registers load defaults at reset; non read-only bits write and read back.
`timescale 1ns/10ps
module pmuc_host_control_port
  import pmuc_pkg::*;
#(
  parameter int RST_STRETCH_CYC = PMUC_RST_STRETCH_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE_N,
  input wire logic LOW_VOLTAGE_GROUP_ENABLE,
  input wire logic HIGH_VOLTAGE_GROUP_ENABLE,
  input wire logic RESET_BUTTON_INPUT_N,
  output logic PROCESSOR_RESET_OUTPUT_N,
  input wire logic [PMUC_NUM_SUPPLIES-1:0] SUPPLY_LOW,
  input wire logic BATTERY_LOW,
  output logic SUPPLY_FAULT_N,
  output logic BATTERY_FAULT_N,
  output logic [PMUC_NUM_SUPPLIES-1:0] REG_ENABLE,
  output logic ALWAYS_ON_REGULATOR_ENABLE,
  output logic BUS_BUSY
);

  localparam int RCW = $clog2(RST_STRETCH_CYC + 1);

  if (RST_STRETCH_CYC < 1) begin : g_bad_stretch
    $error("reset stretch count must be at least one cycle");
  end

  // ---------------- link domain (serial clock) ----------------
  logic start_tog_r, stop_tog_r, start_ack_r;
  pmuc_link_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic ack_en_r, ack_en_nxt;
  logic wr_tog_r, wr_tog_nxt;
  logic [7:0] wr_ptr_r, wr_ptr_nxt;
  logic [7:0] wr_data_r, wr_data_nxt;
  logic sda_low_r;
  logic [7:0] regs_r [PMUC_NUM_REGS];

  // edge catchers clocked by the data line itself; the clock level qualifies them
  always_ff @(negedge SERIAL_DATA_PIN_IN or negedge RESETN) begin
    if (!RESETN) begin
      start_tog_r <= 1'b0;
    end else if (SERIAL_CLOCK_PIN) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge SERIAL_DATA_PIN_IN or negedge RESETN) begin
    if (!RESETN) begin
      stop_tog_r <= 1'b0;
    end else if (SERIAL_CLOCK_PIN) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // start toggle changed during the high phase, so it is settled by the next rising edge
  wire start_new = start_tog_r != start_ack_r;
  wire sda = SERIAL_DATA_PIN_IN;
  wire [7:0] byte_w = {shreg_r[6:0], sda};
  wire last_bit = cnt_r == PMUC_BIT_LAST;
  wire ack_bit = cnt_r == PMUC_BIT_ACK;
  wire ptr_mapped = ptr_r < 8'(PMUC_NUM_REGS);
  // register words only change after a completed write, long before a read can ask for them
  wire [7:0] rd_word = ptr_mapped ? regs_r[ptr_r[3:0]] : 8'h00;
  wire [7:0] ptr_inc = ptr_r + 8'h01;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    ack_en_nxt = ack_en_r;
    wr_tog_nxt = wr_tog_r;
    wr_ptr_nxt = wr_ptr_r;
    wr_data_nxt = wr_data_r;
    if (start_new) begin
      st_nxt = PMUC_ST_ADDR;
      cnt_nxt = 4'h1;
      shreg_nxt = {7'h00, sda};
      ack_en_nxt = 1'b0;
    end else if (st_r != PMUC_ST_IDLE) begin
      if (ack_bit) begin
        cnt_nxt = 4'h0;
        ack_en_nxt = 1'b0;
        case (st_r)
          PMUC_ST_ADDR: begin
            if (shreg_r[0]) begin
              st_nxt = PMUC_ST_RDATA;
              tx_nxt = rd_word;
              ptr_nxt = ptr_inc;
            end else begin
              st_nxt = PMUC_ST_REGSEL;
            end
          end
          PMUC_ST_RDATA: begin
            if (sda) begin
              st_nxt = PMUC_ST_IDLE;
            end else begin
              tx_nxt = rd_word;
              ptr_nxt = ptr_inc;
            end
          end
          default: begin
          end
        endcase
      end else begin
        cnt_nxt = cnt_r + 4'h1;
        shreg_nxt = byte_w;
        if (last_bit) begin
          case (st_r)
            PMUC_ST_ADDR: begin
              if (byte_w[7:1] == PMUC_SLAVE_ADDR) begin
                ack_en_nxt = 1'b1;
              end else begin
                st_nxt = PMUC_ST_IDLE;
              end
            end
            PMUC_ST_REGSEL: begin
              ptr_nxt = byte_w;
              ack_en_nxt = 1'b1;
              st_nxt = PMUC_ST_WDATA;
            end
            PMUC_ST_WDATA: begin
              wr_ptr_nxt = ptr_r;
              wr_data_nxt = byte_w;
              wr_tog_nxt = ~wr_tog_r;
              ptr_nxt = ptr_inc;
              ack_en_nxt = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge SERIAL_CLOCK_PIN or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= PMUC_ST_IDLE;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      ack_en_r <= 1'b0;
      start_ack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      ack_en_r <= ack_en_nxt;
      start_ack_r <= start_tog_r;
    end
  end

  always_ff @(posedge SERIAL_CLOCK_PIN or negedge RESETN) begin
    if (!RESETN) begin
      wr_tog_r <= 1'b0;
      wr_ptr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_tog_r <= wr_tog_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // drive only on falling edges so the line is steady while the clock is high
  wire ack_drive = ack_bit && ack_en_r;
  wire rd_drive = (st_r == PMUC_ST_RDATA) && !cnt_r[3] && !tx_r[~cnt_r[2:0]];
  always_ff @(negedge SERIAL_CLOCK_PIN or negedge RESETN) begin
    if (!RESETN) begin
      sda_low_r <= 1'b0;
    end else begin
      sda_low_r <= ack_drive || rd_drive;
    end
  end

  assign SERIAL_DATA_PIN_OUT = 1'b0;
  assign SERIAL_DATA_PIN_OE_N = ~sda_low_r;

  // ---------------- system domain ----------------
  logic lv_s1_r, lv_s2_r, hv_s1_r, hv_s2_r;
  logic btn_s1_r, btn_s2_r, batt_s1_r, batt_s2_r;
  logic [PMUC_NUM_SUPPLIES-1:0] low_s1_r, low_s2_r;
  logic wr_s1_r, wr_s2_r, wr_s3_r;
  logic [2:0] start_sync_r, stop_sync_r;
  logic busy_r;
  logic [PMUC_NUM_SUPPLIES-1:0] reg_en_r;
  logic supply_fault_n_r, batt_fault_n_r;
  logic [RCW-1:0] rst_cnt_r;
  logic rst_out_n_r;

  always_ff @(posedge CLK_SYS) begin
    lv_s1_r <= LOW_VOLTAGE_GROUP_ENABLE;
    lv_s2_r <= lv_s1_r;
    hv_s1_r <= HIGH_VOLTAGE_GROUP_ENABLE;
    hv_s2_r <= hv_s1_r;
    btn_s1_r <= RESET_BUTTON_INPUT_N;
    btn_s2_r <= btn_s1_r;
    batt_s1_r <= BATTERY_LOW;
    batt_s2_r <= batt_s1_r;
    low_s1_r <= SUPPLY_LOW;
    low_s2_r <= low_s1_r;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
      start_sync_r <= 3'h0;
      stop_sync_r <= 3'h0;
    end else begin
      wr_s1_r <= wr_tog_r;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      start_sync_r <= {start_sync_r[1:0], start_tog_r};
      stop_sync_r <= {stop_sync_r[1:0], stop_tog_r};
    end
  end

  wire start_evt = start_sync_r[2] ^ start_sync_r[1];
  wire stop_evt = stop_sync_r[2] ^ stop_sync_r[1];

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      busy_r <= 1'b0;
    end else if (start_evt) begin
      busy_r <= 1'b1;
    end else if (stop_evt) begin
      busy_r <= 1'b0;
    end
  end

  // pointer and data were set with the toggle and hold for a whole byte time
  wire wr_evt = wr_s2_r ^ wr_s3_r;
  wire wr_hit = wr_evt && (wr_ptr_r < 8'(PMUC_NUM_REGS));
  wire [3:0] wr_idx = wr_ptr_r[3:0];

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      for (int i = 0; i < PMUC_NUM_REGS; i++) begin
        regs_r[i] <= PMUC_REG_DEFAULT[i];
      end
    end else if (wr_hit) begin
      regs_r[wr_idx] <= wr_data_r & PMUC_REG_MASK[wr_idx];
    end
  end

  wire [PMUC_NUM_SUPPLIES-1:0] en_bits = {regs_r[PMUC_REG_ENABLE1[3:0]][3:0], regs_r[PMUC_REG_ENABLE0[3:0]]};
  wire [PMUC_NUM_SUPPLIES-1:0] lv_gate = lv_s2_r ? PMUC_LV_GROUP : '0;
  wire [PMUC_NUM_SUPPLIES-1:0] hv_gate = hv_s2_r ? PMUC_HV_GROUP : '0;
  wire [PMUC_NUM_SUPPLIES-1:0] en_want = en_bits & (lv_gate | hv_gate);
  wire fault_any = |(low_s2_r & reg_en_r);
  wire batt_flt_on = !regs_r[PMUC_REG_BATT[3:0]][PMUC_BATT_FLT_EN_N_BIT];
  wire batt_flt = batt_s2_r && batt_flt_on;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      reg_en_r <= '0;
      supply_fault_n_r <= 1'b1;
      batt_fault_n_r <= 1'b1;
    end else begin
      reg_en_r <= en_want;
      supply_fault_n_r <= !fault_any;
      batt_fault_n_r <= !batt_flt;
    end
  end

  // a press of any length reloads the full count, so short presses still give the minimum
  wire rst_load = !RESETN || !btn_s2_r;
  always_ff @(posedge CLK_SYS) begin
    if (rst_load) begin
      rst_cnt_r <= RCW'(RST_STRETCH_CYC);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rst_out_n_r <= 1'b0;
    end else begin
      rst_out_n_r <= (rst_cnt_r == '0) && btn_s2_r;
    end
  end

  assign PROCESSOR_RESET_OUTPUT_N = rst_out_n_r;
  assign SUPPLY_FAULT_N = supply_fault_n_r;
  assign BATTERY_FAULT_N = batt_fault_n_r;
  assign REG_ENABLE = reg_en_r;
  assign ALWAYS_ON_REGULATOR_ENABLE = 1'b1;
  assign BUS_BUSY = busy_r;

  // ---------------- checks ----------------
  logic [RCW:0] low_len_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || rst_out_n_r) begin
      low_len_r <= '0;
    end else if (!low_len_r[RCW]) begin
      low_len_r <= low_len_r + 1'b1;
    end
  end

  chk_stretch_min_len: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $rose(rst_out_n_r) |-> (low_len_r >= (RCW+1)'(RST_STRETCH_CYC)))
    else $error("processor reset released too early");
  chk_button_forces_rst: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !btn_s2_r |=> !rst_out_n_r ##1 !rst_out_n_r)
    else $error("button press did not hold reset");
  chk_cold_start_rst: assert property (@(posedge CLK_SYS)
    $rose(RESETN) |-> !rst_out_n_r ##1 !rst_out_n_r)
    else $error("reset not asserted after power-on");
  chk_supply_fault_map: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ##1 supply_fault_n_r == !$past(fault_any))
    else $error("supply fault output wrong");
  chk_lv_group_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !lv_s2_r |=> (reg_en_r & PMUC_LV_GROUP) == '0)
    else $error("low-voltage supply on without group enable");
  chk_hv_group_on: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    hv_s2_r |=> (reg_en_r & PMUC_HV_GROUP) == ($past(en_bits) & PMUC_HV_GROUP))
    else $error("high-voltage supply enable wrong");
  chk_batt_fault_out: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    batt_s2_r && batt_flt_on |=> !batt_fault_n_r)
    else $error("battery fault not reported");
  chk_reg_write_back: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    wr_hit |=> regs_r[$past(wr_idx)] == ($past(wr_data_r) & PMUC_REG_MASK[$past(wr_idx)]))
    else $error("register write not stored");
  chk_addr_ignore: assert property (@(posedge SERIAL_CLOCK_PIN) disable iff (!RESETN)
    (!start_new && st_r == PMUC_ST_ADDR && last_bit && byte_w[7:1] != PMUC_SLAVE_ADDR)
    |=> !ack_en_r && st_r == PMUC_ST_IDLE)
    else $error("foreign address acknowledged");
  chk_rx_ack_every: assert property (@(posedge SERIAL_CLOCK_PIN) disable iff (!RESETN)
    (!start_new && last_bit && (st_r == PMUC_ST_REGSEL || st_r == PMUC_ST_WDATA)) |=> ack_en_r && ack_bit)
    else $error("received byte not acknowledged");
  chk_restart_addr: assert property (@(posedge SERIAL_CLOCK_PIN) disable iff (!RESETN)
    start_new |=> st_r == PMUC_ST_ADDR && cnt_r == 4'h1)
    else $error("start did not restart address reception");
endmodule

/* File: hdl/pmuc_pkg.sv */
// constants and types shared by the power unit host control port
package pmuc_pkg;
  localparam logic [6:0] PMUC_SLAVE_ADDR = 7'h46;
  localparam int PMUC_NUM_REGS = 14;
  localparam int PMUC_NUM_SUPPLIES = 12;
  localparam logic [7:0] PMUC_REG_ENABLE0 = 8'h00;
  localparam logic [7:0] PMUC_REG_ENABLE1 = 8'h01;
  localparam logic [7:0] PMUC_REG_BATT = 8'h0d;
  localparam int PMUC_BATT_FLT_EN_N_BIT = 6;
  // enable bit order: linear regs pll..aux_four (0-9), switcher_core, switcher_memory
  localparam logic [11:0] PMUC_LV_GROUP = 12'h443;
  localparam logic [11:0] PMUC_HV_GROUP = 12'hbbc;
  localparam logic [13:0][7:0] PMUC_REG_DEFAULT = {8'h11, 8'h21, 8'h2e, 8'h0d, 8'h0d, 8'h0d, 8'h00,
                                                    8'h0d, 8'h0f, 8'h0d, 8'h0d, 8'h00, 8'h0f, 8'hff};
  // writable bits; all others are unused and read zero
  localparam logic [13:0][7:0] PMUC_REG_MASK = {8'hff, 8'h7f, 8'h7f, 8'h1f, 8'h1f, 8'h1f, 8'h00,
                                                 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'hff, 8'h0f, 8'hff};
  localparam int PMUC_CLK_SYS_HZ = 20000000;
  localparam int PMUC_RST_STRETCH_MS = 50;
  localparam int PMUC_RST_STRETCH_CYC = PMUC_RST_STRETCH_MS * (PMUC_CLK_SYS_HZ / 1000);
  localparam logic [3:0] PMUC_BIT_LAST = 4'h7;
  localparam logic [3:0] PMUC_BIT_ACK = 4'h8;
  typedef enum logic [2:0] {
    PMUC_ST_IDLE = 3'b000,
    PMUC_ST_ADDR = 3'b001,
    PMUC_ST_REGSEL = 3'b010,
    PMUC_ST_WDATA = 3'b011,
    PMUC_ST_RDATA = 3'b100
  } pmuc_link_state_t;
endpackage

/* File: bench/pmuc_i2c_master.sv */
// serial bus master model standing in for the applications processor
`timescale 1ns/10ps
module pmuc_i2c_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // clock stands high outside frames; wire level resolved by the bench
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b1;
    #32 scl = 1'b0;
  endtask
  task automatic stop();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b0;
    #32;
  endtask
  // data moves a quarter period after the falling edge, sampled mid-high
  task automatic xfer_bit(input logic b, output logic r);
    #16 sda_pull = ~b;
    #16 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(nack, r);
  endtask
endmodule

/* File: bench/test_pmu_host_control_port.sv */
// self-checking bench for the power unit host control port
`timescale 1ns/10ps
module test_pmu_host_control_port
  import pmuc_pkg::*;
;
  // short stretch keeps the run brief
  localparam int STR = 20;
  logic clk_sys, resetn, scl, m_pull, sda, oe_n, lv, hv, btn_n, batt_low;
  logic rst_o_n, sfault_n, bfault_n, aon, busy, a, sda_out;
  logic [11:0] supply_low, reg_en;
  logic [7:0] d;
  int errors, check_count, n;
  // pulled-up wire, either side may pull it low; device drives its output value when enabled
  assign sda = ~m_pull & (oe_n | sda_out);
  pmuc_i2c_master u_pmuc_i2c_master (.scl(scl), .sda_pull(m_pull), .sda(sda));
  pmuc_host_control_port #(.RST_STRETCH_CYC(STR)) u_pmuc_host_control_port (
    .CLK_SYS(clk_sys), .RESETN(resetn), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_IN(sda),
    .SERIAL_DATA_PIN_OUT(sda_out), .SERIAL_DATA_PIN_OE_N(oe_n), .LOW_VOLTAGE_GROUP_ENABLE(lv),
    .HIGH_VOLTAGE_GROUP_ENABLE(hv), .RESET_BUTTON_INPUT_N(btn_n), .PROCESSOR_RESET_OUTPUT_N(rst_o_n),
    .SUPPLY_LOW(supply_low), .BATTERY_LOW(batt_low), .SUPPLY_FAULT_N(sfault_n),
    .BATTERY_FAULT_N(bfault_n), .REG_ENABLE(reg_en), .ALWAYS_ON_REGULATOR_ENABLE(aon), .BUS_BUSY(busy));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // sel 1 watches busy, 0 the processor reset; n returns cycles waited
  task automatic wait_for(input logic sel, input logic v, input int lim);
    n = 0;
    while ((sel ? busy : rst_o_n) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        errors++;
        summarize();
      end
    end
  endtask
  task automatic addr(input logic [7:0] r);
    u_pmuc_i2c_master.start();
    u_pmuc_i2c_master.wbyte({PMUC_SLAVE_ADDR, 1'b0}, a);
    check(12'(a), 12'h001);
    check(12'(busy), 12'h001);
    u_pmuc_i2c_master.wbyte(r, a);
    check(12'(a), 12'h001);
  endtask
  task automatic finish_session();
    u_pmuc_i2c_master.stop();
    wait_for(1'b1, 1'b0, 40);
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1);
    addr(r);
    u_pmuc_i2c_master.wbyte(d0, a);
    check(12'(a), 12'h001);
    u_pmuc_i2c_master.wbyte(d1, a);
    check(12'(a), 12'h001);
    finish_session();
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
    addr(r);
    u_pmuc_i2c_master.start();
    u_pmuc_i2c_master.wbyte({PMUC_SLAVE_ADDR, 1'b1}, a);
    check(12'(a), 12'h001);
    u_pmuc_i2c_master.rbyte(1'b0, d);
    check(12'(d), 12'(e0));
    u_pmuc_i2c_master.rbyte(1'b1, d);
    check(12'(d), 12'(e1));
    finish_session();
  endtask
  task automatic t_power_on();
    wait_for(1'b0, 1'b1, STR + 10);
    check(12'(n >= STR), 12'h001);
    check(12'(busy), 12'h000);
    check(12'(aon), 12'h001);
    $display("power-on reset test done");
  endtask
  task automatic t_enables();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      lv <= k[0];
      hv <= k[1];
      cyc(6);
      check(reg_en, (k[0] ? PMUC_LV_GROUP : 12'h000) | (k[1] ? PMUC_HV_GROUP : 12'h000));
    end
    $display("group enable test done");
  endtask
  task automatic t_faults();
    @(posedge clk_sys);
    lv <= 1'b0;
    supply_low <= 12'h001;
    cyc(8);
    check(12'(sfault_n), 12'h001);
    @(posedge clk_sys);
    lv <= 1'b1;
    cyc(8);
    check(12'(sfault_n), 12'h000);
    @(posedge clk_sys);
    supply_low <= 12'h000;
    batt_low <= 1'b1;
    cyc(8);
    check(12'(sfault_n), 12'h001);
    check(12'(bfault_n), 12'h000);
    @(posedge clk_sys);
    batt_low <= 1'b0;
    $display("fault test done");
  endtask
  task automatic t_button();
    @(posedge clk_sys);
    btn_n <= 1'b0;
    cyc(2);
    @(posedge clk_sys);
    btn_n <= 1'b1;
    wait_for(1'b0, 1'b0, 6);
    wait_for(1'b0, 1'b1, STR + 10);
    check(12'(n >= STR), 12'h001);
    $display("button reset test done");
  endtask
  task automatic t_write_read();
    rd(PMUC_REG_ENABLE0, 8'hff, 8'h0f);
    rd(8'h0c, 8'h21, 8'h11);
    wr(PMUC_REG_ENABLE0, 8'h5a, 8'h0c);
    cyc(6);
    check(reg_en, 12'hc5a);
    rd(PMUC_REG_ENABLE0, 8'h5a, 8'h0c);
    wr(8'h03, 8'hff, 8'h0a);
    rd(8'h03, 8'h1f, 8'h0a);
    // second byte lands past the last register: acked, dropped, reads zero
    wr(PMUC_REG_BATT, 8'h51, 8'h33);
    rd(PMUC_REG_BATT, 8'h51, 8'h00);
    @(posedge clk_sys);
    batt_low <= 1'b1;
    cyc(8);
    check(12'(bfault_n), 12'h001);
    @(posedge clk_sys);
    batt_low <= 1'b0;
    $display("write and read test done");
  endtask
  task automatic t_wrong_addr();
    u_pmuc_i2c_master.start();
    u_pmuc_i2c_master.wbyte({7'h47, 1'b0}, a);
    check(12'(a), 12'h000);
    u_pmuc_i2c_master.wbyte(8'h00, a);
    u_pmuc_i2c_master.wbyte(8'h00, a);
    check(12'(a), 12'h000);
    finish_session();
    rd(PMUC_REG_ENABLE0, 8'h5a, 8'h0c);
    $display("foreign address test done");
  endtask
  initial begin
    resetn = 1'b1;
    btn_n = 1'b1;
    lv = 1'b0;
    hv = 1'b0;
    supply_low = 12'h000;
    batt_low = 1'b0;
    errors = 0;
    check_count = 0;
    // a real falling edge, so the link-side asynchronous resets fire in every simulator
    #1 resetn = 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_power_on();
    t_enables();
    t_faults();
    t_button();
    t_write_read();
    t_wrong_addr();
    summarize();
  end
endmodule
